/* src/mtcr_pkg.sv */
// Purpose: shared constants of the MAC test control register bank
// Assumes: byte-wide registers on a byte-addressed user slave port
// Notes: offsets are byte addresses of the user slave port

package mtcr_pkg;

    localparam int ADDR_WIDTH = 16;
    localparam int DATA_WIDTH = 8;
    localparam int THRESH_WIDTH = 9;
    localparam int PAUSE_WIDTH = 16;

    // Register offsets
    localparam logic [15:0] OFFS_VERSION_IDENTIFIER = 16'h8000;
    localparam logic [15:0] OFFS_TEST_CONTROL = 16'h8001;
    localparam logic [15:0] OFFS_TEST_CONTROL_SECOND = 16'h8002;
    localparam logic [15:0] OFFS_MAC_CLIENT_CONTROL = 16'h8003;
    localparam logic [15:0] OFFS_PAUSE_TIME_LOW = 16'h8004;
    localparam logic [15:0] OFFS_PAUSE_TIME_HIGH = 16'h8005;
    localparam logic [15:0] OFFS_AFULL_LOW = 16'h8006;
    localparam logic [15:0] OFFS_AFULL_HIGH = 16'h8007;
    localparam logic [15:0] OFFS_AEMPTY_LOW = 16'h8008;
    localparam logic [15:0] OFFS_AEMPTY_HIGH = 16'h8009;

    // Test control fields
    localparam int TC_SWAP = 0;
    localparam int TC_LOOP = 1;
    localparam int TC_PHY_RESET = 2;
    localparam int TC_CLKSEL = 3;
    localparam logic [7:0] TC_MASK = 8'h0F;

    // MAC client control fields
    localparam int MC_PAUSE_REQ = 0;
    localparam int MC_CTRL_FRAME = 1;
    localparam int MC_FORCE_FULL = 2;
    localparam int MC_FORCE_EMPTY = 3;
    localparam int MC_IGNORE_NEXT = 4;
    localparam logic [7:0] MC_MASK = 8'h1F;

    // Threshold high registers hold one bit
    localparam logic [7:0] TH_HIGH_MASK = 8'h01;

    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

    // Identity code; value is arbitrary
    localparam logic [7:0] DEFAULT_VERSION_ID = 8'h5C;

endpackage

/* src/mtcr_byte_reg.sv */
// Purpose: one writable byte register with a writable-bit mask
// Assumes: synchronous active-high reset
// Notes: bits outside the mask stay zero

`timescale 1ns/1ns

module mtcr_byte_reg #(
    parameter logic [7:0] MASK = 8'hFF
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Write side
    input wire logic writeHit,
    input wire logic [7:0] writeData,
    // Stored value
    output logic [7:0] value
);
    import mtcr_pkg::*;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            value <= RESET_VALUE;
        else if (writeHit)
            value <= writeData & MASK;
    end

endmodule

/* src/mtcr_read_mux.sv */
// Purpose: read-data selection of the register bank
// Assumes: register values already masked
// Notes: unmapped addresses read as zero

`timescale 1ns/1ns

module mtcr_read_mux
(
    // Address
    input wire logic [mtcr_pkg::ADDR_WIDTH-1:0] addr,
    // Register values
    input wire logic [7:0] versionId,
    input wire logic [7:0] testControl,
    input wire logic [7:0] testControlSecond,
    input wire logic [7:0] macClientControl,
    input wire logic [7:0] pauseTimeLow,
    input wire logic [7:0] pauseTimeHigh,
    input wire logic [7:0] almostFullLow,
    input wire logic [7:0] almostFullHigh,
    input wire logic [7:0] almostEmptyLow,
    input wire logic [7:0] almostEmptyHigh,
    // Selected value
    output logic [7:0] readValue
);
    import mtcr_pkg::*;

    assign readValue =
        (addr == OFFS_VERSION_IDENTIFIER) ? versionId :
        (addr == OFFS_TEST_CONTROL) ? testControl :
        (addr == OFFS_TEST_CONTROL_SECOND) ? testControlSecond :
        (addr == OFFS_MAC_CLIENT_CONTROL) ? macClientControl :
        (addr == OFFS_PAUSE_TIME_LOW) ? pauseTimeLow :
        (addr == OFFS_PAUSE_TIME_HIGH) ? pauseTimeHigh :
        (addr == OFFS_AFULL_LOW) ? almostFullLow :
        (addr == OFFS_AFULL_HIGH) ? almostFullHigh :
        (addr == OFFS_AEMPTY_LOW) ? almostEmptyLow :
        (addr == OFFS_AEMPTY_HIGH) ? almostEmptyHigh :
        UNMAPPED_VALUE;

endmodule

/* src/mtcr_regs.sv */
// Purpose: control register bank of the MAC test application
// Assumes: user slave port strobes are one-cycle and synchronous to sys_clk
// Notes: read data is registered one cycle after the read strobe
//
// Contract
// - Version register is read-only, eight bits, always returns fixed code.
// - Test control bit 3 selects receive line clock (1) or pin clock (0).
// - Test control bit 2 drives active-low PHY reset output level.
// - Test control bit 1 enables client-side loopback.
// - Test control bit 0 enables address swap on the loopback path.
// - MAC control bit 4 drives ignore-next-packet directly.
// - Transmit-FIFO-empty is MAC control bit 3 OR loopback FIFO empty.
// - Receive-FIFO-full is MAC control bit 2 OR loopback FIFO full.
// - One loopback FIFO serves both receive and transmit flags.
// - MAC control bit 1 drives transmit control-frame input directly.
// - Pause request is MAC control bit 0 OR loopback FIFO almost full.
// - Pause time low byte gives bits 7:0, high byte bits 15:8.
// - Almost-full threshold is nine bits, bit 8 from high register bit 0.
// - Almost-empty low register gives threshold bits 7:0.
// - Almost-empty high register bit 0 gives threshold bit 8.
// - Every register is eight bits and byte addressable.

`timescale 1ns/1ns

module mtcr_regs #(
    parameter logic [7:0] VERSION_ID = mtcr_pkg::DEFAULT_VERSION_ID
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // User slave port
    input wire logic [mtcr_pkg::ADDR_WIDTH-1:0] slvAddr,
    input wire logic slvWrite,
    input wire logic slvRead,
    input wire logic [mtcr_pkg::DATA_WIDTH-1:0] slvWriteData,
    output logic [mtcr_pkg::DATA_WIDTH-1:0] slvReadData,
    output logic slvReadValid,
    // Loopback FIFO flags
    input wire logic fifoEmpty,
    input wire logic fifoFull,
    input wire logic fifoAlmostFull,
    // Loopback FIFO thresholds
    output logic [mtcr_pkg::THRESH_WIDTH-1:0] almostFullThreshold,
    output logic [mtcr_pkg::THRESH_WIDTH-1:0] almostEmptyThreshold,
    // Test path control
    output logic rxClockSelect,
    output logic phyReset_n,
    output logic loopbackEnable,
    output logic addressSwap,
    // MAC client inputs
    output logic ignoreNextPacket,
    output logic txFifoEmpty,
    output logic rxFifoFull,
    output logic txFifoControlFrame,
    output logic sendPauseRequest,
    output logic [mtcr_pkg::PAUSE_WIDTH-1:0] pauseTime
);
    import mtcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // True when a field bit lies inside its writable mask
    function automatic logic fieldWritable(input logic [7:0] mask, input int pos);
        fieldWritable = (pos >= 0) && (pos < 8) && (mask[pos] == 1'b1);
    endfunction

    // The bank maps one register to each byte of data
    if (DATA_WIDTH != 8)
    begin : gDataWidthCheck
        $error("register data must be one byte wide");
    end

    // Offsets need sixteen address bits
    if (ADDR_WIDTH < 16)
    begin : gAddrWidthCheck
        $error("address too narrow for the register offsets");
    end

    if (PAUSE_WIDTH != 2 * DATA_WIDTH)
    begin : gPauseWidthCheck
        $error("pause time must span two register bytes");
    end

    if (THRESH_WIDTH != DATA_WIDTH + 1)
    begin : gThreshWidthCheck
        $error("thresholds must be one byte plus one bit");
    end

    if (!fieldWritable(TC_MASK, TC_SWAP) || !fieldWritable(TC_MASK, TC_LOOP) ||
        !fieldWritable(TC_MASK, TC_PHY_RESET) || !fieldWritable(TC_MASK, TC_CLKSEL))
    begin : gTestFieldCheck
        $error("test control field outside its writable mask");
    end

    if (!fieldWritable(MC_MASK, MC_PAUSE_REQ) || !fieldWritable(MC_MASK, MC_CTRL_FRAME) ||
        !fieldWritable(MC_MASK, MC_FORCE_FULL) || !fieldWritable(MC_MASK, MC_FORCE_EMPTY) ||
        !fieldWritable(MC_MASK, MC_IGNORE_NEXT))
    begin : gMacFieldCheck
        $error("MAC control field outside its writable mask");
    end

    // Threshold bit 8 is taken from bit 0 of the high registers
    if (!fieldWritable(TH_HIGH_MASK, 0))
    begin : gThreshHighCheck
        $error("threshold high mask must keep bit 0");
    end

    // Reserved bits must stay outside the writable masks
    if ((TC_MASK & 8'hF0) != 8'h00 || (MC_MASK & 8'hE0) != 8'h00 ||
        (TH_HIGH_MASK & 8'hFE) != 8'h00)
    begin : gReservedCheck
        $error("a reserved bit is writable");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    // Strobe and address are arguments so each assign follows them
    function automatic logic hitAt(
        input logic strobe,
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] offs
    );
        hitAt = strobe && (addr == offs);
    endfunction

    wire logic wrTestControl;
    wire logic wrTestControlSecond;
    wire logic wrMacClientControl;
    wire logic wrPauseLow;
    wire logic wrPauseHigh;
    wire logic wrAfullLow;
    wire logic wrAfullHigh;
    wire logic wrAemptyLow;
    wire logic wrAemptyHigh;

    // Each register sits at its own byte address
    // Unmapped and read-only offsets decode to no write
    assign wrTestControl = hitAt(slvWrite, slvAddr, OFFS_TEST_CONTROL);
    assign wrTestControlSecond = hitAt(slvWrite, slvAddr, OFFS_TEST_CONTROL_SECOND);
    assign wrMacClientControl = hitAt(slvWrite, slvAddr, OFFS_MAC_CLIENT_CONTROL);
    assign wrPauseLow = hitAt(slvWrite, slvAddr, OFFS_PAUSE_TIME_LOW);
    assign wrPauseHigh = hitAt(slvWrite, slvAddr, OFFS_PAUSE_TIME_HIGH);
    assign wrAfullLow = hitAt(slvWrite, slvAddr, OFFS_AFULL_LOW);
    assign wrAfullHigh = hitAt(slvWrite, slvAddr, OFFS_AFULL_HIGH);
    assign wrAemptyLow = hitAt(slvWrite, slvAddr, OFFS_AEMPTY_LOW);
    assign wrAemptyHigh = hitAt(slvWrite, slvAddr, OFFS_AEMPTY_HIGH);

    ////////////////////////////////////////////////////////////////////////////
    // Storage; masks keep reserved bits at zero

    logic [7:0] testControl;
    logic [7:0] testControlSecond;
    logic [7:0] macClientControl;
    logic [7:0] pauseTimeLow;
    logic [7:0] pauseTimeHigh;
    logic [7:0] almostFullLow;
    logic [7:0] almostFullHigh;
    logic [7:0] almostEmptyLow;
    logic [7:0] almostEmptyHigh;

    mtcr_byte_reg #(.MASK(TC_MASK)) testControlReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrTestControl),
        .writeData(slvWriteData),
        .value(testControl)
    );

    // Second test control is all reserved, so it keeps nothing
    mtcr_byte_reg #(.MASK(8'h00)) testControlSecondReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrTestControlSecond),
        .writeData(slvWriteData),
        .value(testControlSecond)
    );

    mtcr_byte_reg #(.MASK(MC_MASK)) macClientControlReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrMacClientControl),
        .writeData(slvWriteData),
        .value(macClientControl)
    );

    mtcr_byte_reg #(.MASK(8'hFF)) pauseLowReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrPauseLow),
        .writeData(slvWriteData),
        .value(pauseTimeLow)
    );

    mtcr_byte_reg #(.MASK(8'hFF)) pauseHighReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrPauseHigh),
        .writeData(slvWriteData),
        .value(pauseTimeHigh)
    );

    mtcr_byte_reg #(.MASK(8'hFF)) afullLowReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrAfullLow),
        .writeData(slvWriteData),
        .value(almostFullLow)
    );

    mtcr_byte_reg #(.MASK(TH_HIGH_MASK)) afullHighReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrAfullHigh),
        .writeData(slvWriteData),
        .value(almostFullHigh)
    );

    mtcr_byte_reg #(.MASK(8'hFF)) aemptyLowReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrAemptyLow),
        .writeData(slvWriteData),
        .value(almostEmptyLow)
    );

    mtcr_byte_reg #(.MASK(TH_HIGH_MASK)) aemptyHighReg
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .writeHit(wrAemptyHigh),
        .writeData(slvWriteData),
        .value(almostEmptyHigh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    wire logic [7:0] readValue;

    // Version register has no storage and no write decode
    mtcr_read_mux readMux
    (
        .addr(slvAddr),
        .versionId(VERSION_ID),
        .testControl(testControl),
        .testControlSecond(testControlSecond),
        .macClientControl(macClientControl),
        .pauseTimeLow(pauseTimeLow),
        .pauseTimeHigh(pauseTimeHigh),
        .almostFullLow(almostFullLow),
        .almostFullHigh(almostFullHigh),
        .almostEmptyLow(almostEmptyLow),
        .almostEmptyHigh(almostEmptyHigh),
        .readValue(readValue)
    );

    // Read data holds the last value read until the next read strobe
    wire logic [7:0] next_slvReadData;

    assign next_slvReadData = slvRead ? readValue : slvReadData;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            slvReadValid <= 1'b0;
        else
            slvReadValid <= slvRead;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            slvReadData <= RESET_VALUE;
        else
            slvReadData <= next_slvReadData;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field taps of the control registers

    wire logic clockSelectBit;
    wire logic phyResetBit;
    wire logic loopbackBit;
    wire logic swapBit;
    wire logic ignoreBit;
    wire logic forceEmptyBit;
    wire logic forceFullBit;
    wire logic controlFrameBit;
    wire logic pauseRequestBit;

    assign clockSelectBit = testControl[TC_CLKSEL];
    assign phyResetBit = testControl[TC_PHY_RESET];
    assign loopbackBit = testControl[TC_LOOP];
    assign swapBit = testControl[TC_SWAP];
    assign ignoreBit = macClientControl[MC_IGNORE_NEXT];
    assign forceEmptyBit = macClientControl[MC_FORCE_EMPTY];
    assign forceFullBit = macClientControl[MC_FORCE_FULL];
    assign controlFrameBit = macClientControl[MC_CTRL_FRAME];
    assign pauseRequestBit = macClientControl[MC_PAUSE_REQ];

    ////////////////////////////////////////////////////////////////////////////
    // Test path control

    assign rxClockSelect = clockSelectBit;
    assign phyReset_n = phyResetBit;
    assign loopbackEnable = loopbackBit;
    assign addressSwap = swapBit;

    ////////////////////////////////////////////////////////////////////////////
    // MAC client inputs; one FIFO's flags feed both directions

    // Software bits can only add to the FIFO's own conditions, never mask them
    assign ignoreNextPacket = ignoreBit;
    assign txFifoEmpty = forceEmptyBit | fifoEmpty;
    assign rxFifoFull = forceFullBit | fifoFull;
    assign txFifoControlFrame = controlFrameBit;
    assign sendPauseRequest = pauseRequestBit | fifoAlmostFull;
    assign pauseTime = {pauseTimeHigh, pauseTimeLow};

    ////////////////////////////////////////////////////////////////////////////
    // Loopback FIFO thresholds

    // Bit 8 of a threshold comes from bit 0 of its high register
    function automatic logic [THRESH_WIDTH-1:0] joinThreshold(
        input logic [7:0] high,
        input logic [7:0] low
    );
        joinThreshold = {high[0], low};
    endfunction

    assign almostFullThreshold = joinThreshold(almostFullHigh, almostFullLow);
    assign almostEmptyThreshold = joinThreshold(almostEmptyHigh, almostEmptyLow);

endmodule

/* sim/mtcr_regs_properties.sv */
// Purpose: port checks of the MAC test control register bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound to mtcr_regs from tb
`timescale 1ns/1ns
module mtcr_regs_properties
    import mtcr_pkg::*;
#(
    parameter logic [7:0] VERSION_ID = 8'h00
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Slave port
    input wire logic [mtcr_pkg::ADDR_WIDTH-1:0] slvAddr,
    input wire logic slvWrite,
    input wire logic slvRead,
    input wire logic [mtcr_pkg::DATA_WIDTH-1:0] slvWriteData,
    input wire logic [mtcr_pkg::DATA_WIDTH-1:0] slvReadData,
    input wire logic slvReadValid,
    // FIFO flags and controls
    input wire logic fifoEmpty,
    input wire logic fifoFull,
    input wire logic fifoAlmostFull,
    input wire logic [mtcr_pkg::THRESH_WIDTH-1:0] almostFullThreshold,
    input wire logic [mtcr_pkg::THRESH_WIDTH-1:0] almostEmptyThreshold,
    input wire logic rxClockSelect,
    input wire logic phyReset_n,
    input wire logic loopbackEnable,
    input wire logic addressSwap,
    input wire logic ignoreNextPacket,
    input wire logic txFifoEmpty,
    input wire logic rxFifoFull,
    input wire logic txFifoControlFrame,
    input wire logic sendPauseRequest,
    input wire logic [mtcr_pkg::PAUSE_WIDTH-1:0] pauseTime
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence wrTo(logic [15:0] a);
        slvWrite && slvAddr == a;
    endsequence
    sequence rdOf(logic [15:0] a);
        slvRead && slvAddr == a;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_read_valid: assert property (slvRead |=> slvReadValid)
        else $error("read strobe gave no valid pulse");
    a_version_fixed: assert property (
        rdOf(OFFS_VERSION_IDENTIFIER) |=> slvReadData == VERSION_ID)
        else $error("version read wrong");
    a_test_fields: assert property (wrTo(OFFS_TEST_CONTROL) |=>
        {rxClockSelect, phyReset_n, loopbackEnable, addressSwap} == $past(slvWriteData[3:0]))
        else $error("test control outputs wrong");
    a_mac_direct: assert property (wrTo(OFFS_MAC_CLIENT_CONTROL) |=>
        {ignoreNextPacket, txFifoControlFrame} == {$past(slvWriteData[4]), $past(slvWriteData[1])})
        else $error("mac direct bits wrong");
    a_empty_or: assert property (wrTo(OFFS_MAC_CLIENT_CONTROL) |=>
        txFifoEmpty == ($past(slvWriteData[3]) | fifoEmpty))
        else $error("tx empty merge wrong");
    a_full_or: assert property (wrTo(OFFS_MAC_CLIENT_CONTROL) |=>
        rxFifoFull == ($past(slvWriteData[2]) | fifoFull))
        else $error("rx full merge wrong");
    a_pause_or: assert property (wrTo(OFFS_MAC_CLIENT_CONTROL) |=>
        sendPauseRequest == ($past(slvWriteData[0]) | fifoAlmostFull))
        else $error("pause request merge wrong");
    a_pause_low: assert property (wrTo(OFFS_PAUSE_TIME_LOW) |=>
        pauseTime[7:0] == $past(slvWriteData))
        else $error("pause time low byte wrong");
    a_afull_high: assert property (wrTo(OFFS_AFULL_HIGH) |=>
        almostFullThreshold[8] == $past(slvWriteData[0]))
        else $error("almost full bit 8 wrong");
    a_aempty_high: assert property (wrTo(OFFS_AEMPTY_HIGH) |=>
        almostEmptyThreshold[8] == $past(slvWriteData[0]))
        else $error("almost empty bit 8 wrong");
    a_valid_pulse: assert property (!slvRead |=> !slvReadValid)
        else $error("valid pulse outlived its read");
    a_reset_clear: assert property ($fell(rst) |->
        !phyReset_n && pauseTime == 16'h0000 && !slvReadValid && slvReadData == 8'h00)
        else $error("outputs not cleared by reset");
endmodule

/* sim/mtcr_fifo_model.sv */
// Purpose: loopback FIFO flag source facing the register bank
// Assumes: flags change off the sampling edge
// Notes: level bit 0 empty, 1 full, 2 almost full
`timescale 1ns/1ns
module mtcr_fifo_model
(
    // Clock and requested flag levels
    input wire logic sys_clk,
    input wire logic [2:0] level,
    // Loopback FIFO flags
    output logic fifoEmpty,
    output logic fifoFull,
    output logic fifoAlmostFull
);
    initial {fifoAlmostFull, fifoFull, fifoEmpty} = 3'h0;
    // One FIFO feeds both receive and transmit flags
    always @(negedge sys_clk)
        {fifoAlmostFull, fifoFull, fifoEmpty} <= level;
endmodule

/* sim/tb.sv */
// Purpose: self-checking bench of the MAC test control register bank
// Assumes: inputs driven at the falling edge
// Notes: row table first, then bit walks, flag merges and corner cases
`timescale 1ns/1ns
module tb;
    import mtcr_pkg::*;
    typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r0; logic [7:0] r1;} mtcr_row_type;
    // Arbitrary identity value
    localparam logic [7:0] VID = 8'h3A;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic slvWrite = 1'b0;
    logic slvRead = 1'b0;
    logic [15:0] slvAddr = 16'h0000;
    logic [7:0] slvWriteData = 8'h00;
    logic [7:0] slvReadData, d;
    logic [2:0] level = 3'h0;
    logic slvReadValid, fifoEmpty, fifoFull, fifoAlmostFull, rxClockSelect, phyReset_n;
    logic loopbackEnable, addressSwap, ignoreNextPacket, txFifoEmpty, rxFifoFull;
    logic txFifoControlFrame, sendPauseRequest;
    logic [8:0] almostFullThreshold, almostEmptyThreshold;
    logic [15:0] pauseTime;
    int n_fail = 0;
    int n_compared = 0;
    mtcr_row_type rows [11] = '{'{16'h8000, 8'h33, VID, VID}, '{16'h8001, 8'hFF, 8'h00, 8'h0F},
        '{16'h8002, 8'hA5, 8'h00, 8'h00}, '{16'h8003, 8'hE0, 8'h00, 8'h00},
        '{16'h8004, 8'h34, 8'h00, 8'h34}, '{16'h8005, 8'h12, 8'h00, 8'h12},
        '{16'h8006, 8'hAB, 8'h00, 8'hAB}, '{16'h8007, 8'hFF, 8'h00, 8'h01},
        '{16'h8008, 8'hCD, 8'h00, 8'hCD}, '{16'h8009, 8'hFF, 8'h00, 8'h01},
        '{16'h800A, 8'h55, 8'h00, 8'h00}};
    always #20 sys_clk = ~sys_clk;
    mtcr_regs #(.VERSION_ID(VID)) u_mtcr_regs (.sys_clk, .rst, .slvAddr, .slvWrite, .slvRead,
        .slvWriteData, .slvReadData, .slvReadValid, .fifoEmpty, .fifoFull, .fifoAlmostFull,
        .almostFullThreshold, .almostEmptyThreshold, .rxClockSelect, .phyReset_n,
        .loopbackEnable, .addressSwap, .ignoreNextPacket, .txFifoEmpty, .rxFifoFull,
        .txFifoControlFrame, .sendPauseRequest, .pauseTime);
    mtcr_fifo_model u_mtcr_fifo_model (.sys_clk, .level, .fifoEmpty, .fifoFull, .fifoAlmostFull);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] w);
        @(negedge sys_clk);
        slvAddr = a;
        slvWriteData = w;
        slvWrite = 1'b1;
        @(negedge sys_clk);
        slvWrite = 1'b0;
    endtask
    // Valid is high in the cycle after the taking edge
    task automatic rd(input logic [15:0] a);
        @(negedge sys_clk);
        slvAddr = a;
        slvRead = 1'b1;
        @(negedge sys_clk);
        slvRead = 1'b0;
        chk(slvReadValid, 16'h1);
        d = slvReadData;
    endtask
    task automatic close_out;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        chk({phyReset_n, slvReadValid, slvReadData, pauseTime}, 16'h0000);
        foreach (rows[i])
        begin
            rd(rows[i].a);
            chk(d, rows[i].r0);
        end
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk(d, rows[i].r1);
        end
        chk(pauseTime, 16'h1234);
        chk(almostFullThreshold, 16'h01AB);
        chk(almostEmptyThreshold, 16'h01CD);
        for (int k = 0; k < 4; k++)
        begin
            wr(16'h8001, 8'h01 << k);
            chk({rxClockSelect, phyReset_n, loopbackEnable, addressSwap}, 16'h1 << k);
        end
        for (int k = 0; k < 5; k++)
        begin
            wr(16'h8003, 8'h01 << k);
            chk({ignoreNextPacket, txFifoEmpty, rxFifoFull, txFifoControlFrame, sendPauseRequest},
                16'h1 << k);
        end
        wr(16'h8003, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            level = k[2:0];
            repeat (2) @(negedge sys_clk);
            chk({sendPauseRequest, rxFifoFull, txFifoEmpty}, 16'(k));
        end
        level = 3'h0;
        wr(16'h8003, 8'h0D);
        chk({sendPauseRequest, rxFifoFull, txFifoEmpty}, 16'h0007);
        @(negedge sys_clk);
        slvAddr = 16'h8004;
        slvWriteData = 8'h99;
        {slvRead, slvWrite} = 2'b11;
        @(negedge sys_clk);
        {slvRead, slvWrite} = 2'b00;
        chk(slvReadData, 16'h0034);
        rd(16'h8004);
        chk(d, 16'h0099);
        @(negedge sys_clk);
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        chk({phyReset_n, txFifoEmpty, pauseTime, almostFullThreshold, almostEmptyThreshold,
            slvReadData}, 16'h0000);
        close_out();
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        close_out();
    end
endmodule
bind mtcr_regs mtcr_regs_properties #(.VERSION_ID(VERSION_ID)) u_props (.sys_clk, .rst,
    .slvAddr, .slvWrite, .slvRead, .slvWriteData, .slvReadData, .slvReadValid, .fifoEmpty,
    .fifoFull, .fifoAlmostFull, .almostFullThreshold, .almostEmptyThreshold, .rxClockSelect,
    .phyReset_n,
    .loopbackEnable, .addressSwap, .ignoreNextPacket, .txFifoEmpty, .rxFifoFull,
    .txFifoControlFrame, .sendPauseRequest, .pauseTime);
